// ==== hw/spfe_front_end.sv ====
`timescale 1ns/1ps
module spfe_front_end
   import spfe_pkg::*;
#(
   parameter int SAMP_W = 12,
   parameter int LINE_W = 11
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        pclk,
   input  wire logic [19:0] din,
   input  wire spfe_pins_t  pins,
   output logic             din_lo_oe,
   output spfe_out_t        ser_out,
   output logic             sd_rate,
   output logic [7:0]       proc_enable
);
   if (SAMP_W < 4 || SAMP_W > 16 || LINE_W < 4 || LINE_W > 16) begin : g_bad_width
      $error("spfe_front_end: counter width out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; the parallel clock is sampled, not used as a clock
   logic [2:0]  pclk_r;
   logic [19:0] din_s1_r, din_s2_r;
   spfe_pins_t  pin_s1_r, pin_s2_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pclk_r   <= 3'h0;
         din_s1_r <= 20'h0_0000;
         din_s2_r <= 20'h0_0000;
         pin_s1_r <= '0;
         pin_s2_r <= '0;
      end else begin
         pclk_r   <= {pclk_r[1:0], pclk};
         din_s1_r <= din;
         din_s2_r <= din_s1_r;
         pin_s1_r <= pins;
         pin_s2_r <= pin_s1_r;
      end
   end

   logic cap;
   assign cap = pclk_r[1] & ~pclk_r[2];                            // R1

   spfe_mode_t mode;
   always_comb begin
      if (pin_s2_r.processing_select && !pin_s2_r.transport_mode_select) begin
         mode = MODE_VIDEO;                                        // R2
      end else if (!pin_s2_r.processing_select && pin_s2_r.transport_mode_select
                   && pin_s2_r.rate_select) begin
         mode = MODE_TS;                                           // R22
      end else if (!pin_s2_r.processing_select
                   && !pin_s2_r.transport_mode_select) begin
         mode = MODE_THRU;                                         // R23
      end else begin
         mode = MODE_IDLE;
      end
   end

   // Lower lane is input only and never driven
   assign din_lo_oe = 1'b0;                                        // R5
   assign sd_rate   = pin_s2_r.rate_select;                        // R26

   ////////////////////////////////////////////////////////////////////////
   // Lane steering
   logic      wide;
   spfe_out_t out_nxt;
   assign wide = pin_s2_r.input_width_select;                      // R3

   always_comb begin
      out_nxt = '0;
      case (mode)
         MODE_VIDEO: begin
            out_nxt.valid    = cap;
            out_nxt.width20  = wide;
            out_nxt.word     = wide ? din_s2_r : {din_s2_r[19:10], 10'h000}; // R4 R5
            out_nxt.scramble = 1'b1;                               // R11
            out_nxt.nrzi     = 1'b1;                               // R11
         end
         MODE_TS: begin
            out_nxt.valid    = cap;
            out_nxt.enc8b10b = 1'b1;                               // R12 R6
            if (din_s2_r[19]) begin
               out_nxt.word[7:0] = K28_5;                          // R8 R24
               out_nxt.k         = 1'b1;
            end else begin
               out_nxt.word[7:0] = din_s2_r[17:10];                // R7
               out_nxt.k         = din_s2_r[18];                   // R8 R25
            end
         end
         MODE_THRU: begin
            out_nxt.valid   = cap;
            out_nxt.width20 = wide;
            out_nxt.word    = wide ? din_s2_r : {din_s2_r[19:10], 10'h000}; // R9
         end
         default: begin
            out_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ser_out <= '0;
      end else begin
         ser_out.valid <= out_nxt.valid;
         if (out_nxt.valid) begin
            ser_out <= out_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Flywheel timing reference
   logic [7:0]  disable_r;
   logic [9:0]  w1_r, w2_r, w3_r;
   logic        eh_r, ev_r, ef_r;
   logic        step, trs_hit, cur_h, cur_v, cur_f;
   logic [3:0]  adj;

   assign step    = cap && mode == MODE_VIDEO;                     // R13
   assign trs_hit = w3_r[9:2] == TRS_ONES && w2_r[9:2] == TRS_ZERO
                    && w1_r[9:2] == TRS_ZERO;                      // R16

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         w1_r <= 10'h000;
         w2_r <= 10'h000;
         w3_r <= 10'h000;
         eh_r <= 1'b0;
         ev_r <= 1'b0;
         ef_r <= 1'b0;
      end else if (step) begin
         w1_r <= din_s2_r[19:10];
         w2_r <= w1_r;
         w3_r <= w2_r;
         if (trs_hit) begin
            eh_r <= din_s2_r[10 + BIT_XYZ_H];                      // R16
            ev_r <= din_s2_r[10 + BIT_XYZ_V];
            ef_r <= din_s2_r[10 + BIT_XYZ_F];
         end
      end
   end

   always_comb begin
      if (pin_s2_r.embedded_timing_select) begin
         cur_h = eh_r;
         cur_v = ev_r;
         cur_f = ef_r;
         adj   = ADJ_EMB;
      end else begin
         cur_h = pin_s2_r.h;                                       // R15
         cur_v = pin_s2_r.v;
         cur_f = pin_s2_r.f;
         // Code-based H leaves the start word group inside the low time
         adj   = disable_r[BIT_H_CONFIG] ? ADJ_TRS_H : ADJ_NONE;   // R19 R20
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Raster counters
   logic [SAMP_W-1:0] samp_c_r, act_c_r, samp_tot_r, samp_act_r;
   logic [LINE_W-1:0] line_c_r, actl_c_r, line_tot_r, line_act_r;
   logic              ph_r, lv_r, lf_r, saw_f_r;
   logic              line_ev, frame_ev, vrise;
   spfe_fw_t          fw_r;

   assign line_ev  = step && cur_h && !ph_r;
   assign vrise    = line_ev && cur_v && !lv_r;
   assign frame_ev = line_ev && ((lf_r && !cur_f) || (!saw_f_r && vrise));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         samp_c_r   <= '0;
         act_c_r    <= '0;
         line_c_r   <= '0;
         actl_c_r   <= '0;
         samp_tot_r <= '0;
         samp_act_r <= '0;
         line_tot_r <= '0;
         line_act_r <= '0;
         ph_r       <= 1'b0;
         lv_r       <= 1'b0;
         lf_r       <= 1'b0;
         saw_f_r    <= 1'b0;
      end else if (mode != MODE_VIDEO) begin
         samp_c_r <= '0;                                           // R13
         act_c_r  <= '0;
         line_c_r <= '0;
         actl_c_r <= '0;
         ph_r     <= 1'b0;
         saw_f_r  <= 1'b0;
      end else if (step) begin
         ph_r <= cur_h;
         if (line_ev) begin
            samp_tot_r <= samp_c_r;                                // R14
            samp_act_r <= act_c_r - SAMP_W'(adj);
            samp_c_r   <= SAMP_W'(1);
            act_c_r    <= '0;
            lv_r       <= cur_v;
            lf_r       <= cur_f;
            saw_f_r    <= saw_f_r | cur_f;
            line_c_r   <= frame_ev ? LINE_W'(1) : line_c_r + LINE_W'(1);
            if (frame_ev) begin
               line_tot_r <= line_c_r;                             // R14
            end
            if (vrise) begin
               line_act_r <= actl_c_r;                             // R14
               actl_c_r   <= '0;
            end else if (!cur_v) begin
               actl_c_r <= actl_c_r + LINE_W'(1);
            end
         end else begin
            samp_c_r <= samp_c_r + SAMP_W'(1);
            if (!cur_h) begin
               act_c_r <= act_c_r + SAMP_W'(1);
            end
         end
      end
   end

   // Lock state: one full frame between boundaries before lock
   logic mismatch;
   assign mismatch = (frame_ev && line_c_r != line_tot_r)
                     || (line_ev && samp_c_r != samp_tot_r);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fw_r <= FW_SEEK;
      end else if (mode != MODE_VIDEO) begin
         fw_r <= FW_SEEK;                                          // R13
      end else begin
         case (fw_r)
            FW_SEEK: begin
               if (frame_ev) begin
                  fw_r <= FW_LEARN;
               end
            end
            FW_LEARN: begin
               if (frame_ev) begin
                  fw_r <= FW_LOCK;                                 // R17
               end
            end
            FW_LOCK: begin
               if (mismatch) begin
                  fw_r <= FW_LEARN;                                // R18
               end
            end
            default: begin
               fw_r <= FW_SEEK;
            end
         endcase
      end
   end

   // Published raster figures; frozen while standard detection is disabled
   logic [SAMP_W-1:0] rs_tot_r, rs_act_r;
   logic [LINE_W-1:0] rs_lines_r, rs_actl_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rs_tot_r   <= '0;
         rs_act_r   <= '0;
         rs_lines_r <= '0;
         rs_actl_r  <= '0;
      end else if (frame_ev && fw_r == FW_LOCK && !disable_r[BIT_STD_DET]) begin
         rs_tot_r   <= samp_tot_r;                                 // R21
         rs_act_r   <= samp_act_r;
         rs_lines_r <= line_c_r;
         rs_actl_r  <= line_act_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic       wr_pend_r;
   logic [5:0] wr_idx_r;
   logic       acc;
   logic [5:0] a_idx;
   logic [31:0] rd_nxt;

   assign acc       = hsel && htrans[1] && hready;
   assign a_idx     = haddr[7:2];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign proc_enable = ~disable_r;                                // R21

   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (a_idx)
         IDX_DISABLE: rd_nxt[7:0] = disable_r;
         IDX_VSTD: begin
            rd_nxt[BIT_LOCK]     = fw_r == FW_LOCK;
            rd_nxt[BIT_INT_PROG] = saw_f_r;
         end
         IDX_RS1: rd_nxt[SAMP_W-1:0] = rs_act_r;
         IDX_RS2: rd_nxt[SAMP_W-1:0] = rs_tot_r;
         IDX_RS3: rd_nxt[LINE_W-1:0] = rs_lines_r;
         IDX_RS4: rd_nxt[LINE_W-1:0] = rs_actl_r;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_idx_r  <= 6'h00;
         hrdata    <= 32'h0000_0000;
      end else begin
         wr_pend_r <= acc && hwrite;
         wr_idx_r  <= a_idx;
         if (acc && !hwrite) begin
            hrdata <= rd_nxt;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         disable_r <= DISABLE_RST;                                 // R21
      end else if (wr_pend_r && wr_idx_r == IDX_DISABLE) begin
         disable_r <= hwdata[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   property p_capture;
      @(posedge hclk) disable iff (!hresetn)
      cap && mode != MODE_IDLE |=> ser_out.valid;
   endproperty
   a_capture: assert property (p_capture) else $error("capture lost"); // R1
   property p_video_mode;
      @(posedge hclk) disable iff (!hresetn)
      cap && pin_s2_r.processing_select && !pin_s2_r.transport_mode_select
      |=> ser_out.scramble && ser_out.nrzi;
   endproperty
   a_video_mode: assert property (p_video_mode) else $error("video not taken"); // R2
   property p_ts_narrow;
      @(posedge hclk) disable iff (!hresetn)
      ser_out.valid && ser_out.enc8b10b |-> !ser_out.width20;
   endproperty
   a_ts_narrow: assert property (p_ts_narrow) else $error("transport wide"); // R6
   property p_ts_byte;
      @(posedge hclk) disable iff (!hresetn)
      cap && mode == MODE_TS && !din_s2_r[19]
      |=> ser_out.word[7:0] == $past(din_s2_r[17:10]) && ser_out.k == $past(din_s2_r[18]);
   endproperty
   a_ts_byte: assert property (p_ts_byte) else $error("transport byte wrong"); // R7
   property p_sync;
      @(posedge hclk) disable iff (!hresetn)
      cap && mode == MODE_TS && din_s2_r[19] |=> ser_out.word[7:0] == K28_5 && ser_out.k;
   endproperty
   a_sync: assert property (p_sync) else $error("comma missing"); // R24
   property p_lower;
      @(posedge hclk) disable iff (!hresetn)
      cap && mode == MODE_VIDEO && !wide |=> ser_out.word[9:0] == 10'h000;
   endproperty
   a_lower: assert property (p_lower) else $error("lower lane used"); // R5
   property p_thru;
      @(posedge hclk) disable iff (!hresetn)
      cap && mode == MODE_THRU |=> ser_out.word == ($past(wide) ? $past(din_s2_r)
      : {$past(din_s2_r[19:10]), 10'h000}) && !ser_out.scramble && !ser_out.enc8b10b;
   endproperty
   a_thru: assert property (p_thru) else $error("through data altered"); // R9
   property p_fly_off;
      @(posedge hclk) disable iff (!hresetn)
      mode != MODE_VIDEO |=> fw_r == FW_SEEK && samp_c_r == '0;
   endproperty
   a_fly_off: assert property (p_fly_off) else $error("flywheel active"); // R13
   property p_lock;
      @(posedge hclk) disable iff (!hresetn)
      fw_r != FW_LOCK ##1 fw_r == FW_LOCK |-> $past(frame_ev) && $past(fw_r) == FW_LEARN;
   endproperty
   a_lock: assert property (p_lock) else $error("early lock"); // R17
   property p_relearn;
      @(posedge hclk) disable iff (!hresetn)
      fw_r == FW_LOCK && mismatch && mode == MODE_VIDEO |=> fw_r == FW_LEARN;
   endproperty
   a_relearn: assert property (p_relearn) else $error("mismatch ignored"); // R18
   property p_dis_rst;
      @(posedge hclk) disable iff (!hresetn)
      !wr_pend_r |=> $stable(disable_r);
   endproperty
   a_dis_rst: assert property (p_dis_rst) else $error("enable bank moved"); // R21

   c_lock: cover property (@(posedge hclk) disable iff (!hresetn) fw_r == FW_LOCK);
   c_comma: cover property (@(posedge hclk) disable iff (!hresetn)
      ser_out.valid && ser_out.k && ser_out.enc8b10b);
   c_thru: cover property (@(posedge hclk) disable iff (!hresetn)
      ser_out.valid && ser_out.width20 && !ser_out.scramble);
   c_write: cover property (@(posedge hclk) disable iff (!hresetn)
      wr_pend_r && wr_idx_r == IDX_DISABLE);
endmodule

// ==== hw/spfe_pkg.sv ====
// Behaviour
// R1: capture words on parallel clock rising edge
// R2: video mode: processing high, transport low
// R3: width pin sets external bus width
// R4: 20-bit video: luma upper, chroma lower
// R5: 10-bit video: upper lane only, lower ignored
// R6: transport mode forces 10-bit input
// R7: transport byte from upper bits 17..10
// R8: bit 19 sync request, bit 18 special
// R9: data-through passes words unchanged
// R10: source supplies clock matching the format
// R11: video mode scrambles then NRZI encodes
// R12: transport mode 8b/10b encodes with fill
// R13: flywheel runs in video mode only
// R14: flywheel tracks four raster counts
// R15: timing select low: lock external strobes
// R16: timing select high: lock embedded codes
// R17: lock declared after one complete frame
// R18: keep monitoring timing after lock
// R19: blanking style low: H covers reference words
// R20: blanking style high: H follows code H
// R21: extras enabled at reset, disabled by register
// R22: transport mode: processing low, transport, rate high
// R23: data-through: processing and transport both low
// R24: sync request inserts comma before encoding
// R25: source flags special characters on bit 18
// R26: rate pin high means SD, low HD
package spfe_pkg;
   typedef enum {MODE_IDLE, MODE_VIDEO, MODE_TS, MODE_THRU} spfe_mode_t;
   typedef enum {FW_SEEK, FW_LEARN, FW_LOCK} spfe_fw_t;

   typedef struct packed {
      logic processing_select;
      logic transport_mode_select;
      logic rate_select;
      logic input_width_select;
      logic embedded_timing_select;
      logic h;
      logic v;
      logic f;
   } spfe_pins_t;

   typedef struct packed {
      logic        valid;
      logic [19:0] word;
      logic        k;
      logic        width20;
      logic        scramble;
      logic        nrzi;
      logic        enc8b10b;
   } spfe_out_t;

   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_DISABLE = 6'h00;
   localparam logic [5:0] IDX_VSTD    = 6'h04;
   localparam logic [5:0] IDX_RS1     = 6'h0E;
   localparam logic [5:0] IDX_RS2     = 6'h0F;
   localparam logic [5:0] IDX_RS3     = 6'h10;
   localparam logic [5:0] IDX_RS4     = 6'h11;

   localparam logic [7:0] DISABLE_RST = 8'h00;
   localparam int         BIT_H_CONFIG = 6;
   localparam int         BIT_STD_DET  = 7;
   localparam int         BIT_LOCK     = 8;
   localparam int         BIT_INT_PROG = 9;

   localparam logic [7:0] K28_5       = 8'hBC;
   localparam logic [7:0] TRS_ONES    = 8'hFF;
   localparam logic [7:0] TRS_ZERO    = 8'h00;
   localparam int         BIT_XYZ_F   = 8;
   localparam int         BIT_XYZ_V   = 7;
   localparam int         BIT_XYZ_H   = 6;
   localparam logic [3:0] ADJ_EMB     = 4'h3;
   localparam logic [3:0] ADJ_TRS_H   = 4'h4;
   localparam logic [3:0] ADJ_NONE    = 4'h0;
endpackage

// ==== tb/serializer_parallel_input_front_end_tb_top.sv ====
`timescale 1ns/1ps
module serializer_parallel_input_front_end_tb_top;
   import spfe_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        pclk;
   logic [19:0] din;
   spfe_pins_t  pins;
   logic        din_lo_oe;
   spfe_out_t   ser_out;
   logic        sd_rate;
   logic [7:0]  proc_enable;
   logic        lo_float;
   logic [31:0] rd;
   int          mismatches;
   int          checks_done;

   assign hready = hreadyout;

   spfe_front_end dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pclk(pclk), .din(din),
      .pins(pins), .din_lo_oe(din_lo_oe), .ser_out(ser_out), .sd_rate(sd_rate),
      .proc_enable(proc_enable));

   spfe_src_model src (.hclk(hclk), .lo_float(lo_float), .pclk(pclk), .din(din));

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) check("hready wait", 32'h0000_0000, 32'h0000_0001);
   endtask

   // Address phase held until hready, then data phase until hready again
   task automatic ahb_xfer(input logic [5:0] idx, input logic wr, input logic [31:0] wd,
                           output logic [31:0] data);
      hsel   <= 1'b1;
      haddr  <= {idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      hsize  <= 3'b010;
      wait_ready();
      htrans <= 2'b00;
      hsel   <= 1'b0;
      hwdata <= wd;
      wait_ready();
      data = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask

   task automatic reg_read_chk(input logic [5:0] idx, input logic [31:0] exp);
      ahb_xfer(idx, 1'b0, 32'h0000_0000, rd);
      check("register read", rd, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // cfg: processing, transport, rate, width; fl: valid,k,width20,scramble,nrzi,enc
   task automatic run_case(input logic [3:0] cfg, input logic [19:0] w,
                           input logic [19:0] exp, input logic [19:0] msk,
                           input logic [5:0] fl);
      spfe_out_t cap;
      logic      got;
      got = 1'b0;
      cap = '0;
      pins     <= {cfg, 4'b0000};
      lo_float <= ~cfg[0] | (~cfg[3] & cfg[2]);
      repeat (4) @(posedge hclk);
      fork
         src.put_word(w);
         for (int n = 0; n < 16 && !got; n++) begin
            @(posedge hclk);
            #1;
            if (ser_out.valid === 1'b1) begin
               got = 1'b1;
               cap = ser_out;
            end
         end
      join
      check("valid", {31'h0, got}, {31'h0, fl[5]});
      if (got) begin
         check("word", {12'h000, cap.word & msk}, {12'h000, exp});
         check("k", {31'h0, cap.k}, {31'h0, fl[4]});
         check("width20", {31'h0, cap.width20}, {31'h0, fl[3]});
         check("scramble", {31'h0, cap.scramble}, {31'h0, fl[2]});
         check("nrzi", {31'h0, cap.nrzi}, {31'h0, fl[1]});
         check("enc8b10b", {31'h0, cap.enc8b10b}, {31'h0, fl[0]});
      end
      check("sd_rate", {31'h0, sd_rate}, {31'h0, cfg[1]});
      check("din_lo_oe", {31'h0, din_lo_oe}, 32'h0000_0000);
   endtask

   // One raster word in video mode; the strobes go on the pins with the word
   task automatic raster_word(input logic h, input logic v);
      pins <= {4'b1011, 1'b0, h, v, 1'b0};
      src.put_word(20'h0_0000);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      stop_test();
   end

   initial begin
      mismatches  = 0;
      checks_done = 0;
      hresetn     = 1'b0;
      hsel        = 1'b0;
      haddr       = 8'h00;
      htrans      = 2'b00;
      hwrite      = 1'b0;
      hsize       = 3'b010;
      hwdata      = 32'h0000_0000;
      pins        = '0;
      lo_float    = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("proc_enable", {24'h0, proc_enable}, 32'h0000_00FF);
      check("hreadyout", {31'h0, hreadyout}, 32'h0000_0001);
      reg_read_chk(IDX_DISABLE, 32'h0000_0000);
      reg_read_chk(IDX_VSTD, 32'h0000_0000);
      reg_read_chk(IDX_RS1, 32'h0000_0000);
      reg_read_chk(IDX_RS2, 32'h0000_0000);
      reg_read_chk(IDX_RS3, 32'h0000_0000);
      reg_read_chk(IDX_RS4, 32'h0000_0000);
      ahb_xfer(IDX_DISABLE, 1'b1, 32'h0000_0041, rd);
      reg_read_chk(IDX_DISABLE, 32'h0000_0041);
      check("proc_enable", {24'h0, proc_enable}, 32'h0000_00BE);
      // Unmapped index: write dropped, reads zero
      ahb_xfer(6'h3F, 1'b1, 32'hFFFF_FFFF, rd);
      reg_read_chk(6'h3F, 32'h0000_0000);
      ahb_xfer(IDX_DISABLE, 1'b1, 32'h0000_0000, rd);
      // The register takes the data phase word at the last edge of the write; the check sees the new value only after this edge
      @(posedge hclk);
      check("proc_enable", {24'h0, proc_enable}, 32'h0000_00FF);
      run_case(4'b1011, 20'hA_BCDE, 20'hA_BCDE, 20'hF_FFFF, 6'b101110);
      run_case(4'b1001, 20'h5_4321, 20'h5_4321, 20'hF_FFFF, 6'b101110);
      run_case(4'b1010, 20'hC_F0A5, 20'hC_F000, 20'hF_FFFF, 6'b100110);
      run_case(4'b0111, 20'h1_6800, 20'h0_005A, 20'h0_00FF, 6'b100001);
      run_case(4'b0110, 20'h4_7000, 20'h0_001C, 20'h0_00FF, 6'b110001);
      run_case(4'b0111, 20'h8_CC00, 20'h0_00BC, 20'h0_00FF, 6'b110001);
      run_case(4'b0011, 20'h3_9E71, 20'h3_9E71, 20'hF_FFFF, 6'b101000);
      run_case(4'b0000, 20'h7_7777, 20'h7_7400, 20'hF_FFFF, 6'b100000);
      // Progressive raster on external strobes: 4 words a line, 4 lines a frame,
      // H and V high for the first two of each; lock takes two frame starts
      for (int n = 0; n < 33; n++) begin
         raster_word(n[1:0] < 2'h2, n[3:2] < 2'h2);
      end
      reg_read_chk(IDX_VSTD, 32'h0000_0100);
      reg_read_chk(IDX_RS1, 32'h0000_0002);
      reg_read_chk(IDX_RS2, 32'h0000_0004);
      reg_read_chk(IDX_RS3, 32'h0000_0004);
      reg_read_chk(IDX_RS4, 32'h0000_0002);
      // A short line after lock must drop it back to learning
      raster_word(1'b0, 1'b0);
      raster_word(1'b1, 1'b0);
      reg_read_chk(IDX_VSTD, 32'h0000_0000);
      run_case(4'b0101, 20'h2_2222, 20'h0_0000, 20'h0_0000, 6'b000000);
      reg_read_chk(IDX_VSTD, 32'h0000_0000);
      stop_test();
   end
endmodule

// ==== tb/spfe_src_model.sv ====
`timescale 1ns/1ps
module spfe_src_model (
   input  wire logic        hclk,
   input  wire logic        lo_float,
   output logic             pclk,
   output logic [19:0]      din
);
   logic [9:0] hi_r    = 10'h000;
   logic [9:0] lo_r    = 10'h000;
   logic [9:0] noise_r = 10'h155;

   initial pclk = 1'b0;

   // A released lower lane must not look stable, or a wrong capture could pass
   always @(posedge hclk) noise_r <= ~noise_r;

   assign din = {hi_r, lo_float ? noise_r : lo_r};

   ////////////////////////////////////////////////////////////////////////////
   // One word per clock rise; data launched with the rising edge and held
   // across it. The clock is scaled down, as the front end oversamples it.
   task automatic put_word(input logic [19:0] w);
      @(posedge hclk);
      hi_r <= w[19:10];
      lo_r <= w[9:0];
      pclk <= 1'b1;
      repeat (4) @(posedge hclk);
      pclk <= 1'b0;
      repeat (4) @(posedge hclk);
   endtask
endmodule
